//--- pkg/ovc_pkg.sv
package ovc_pkg;

  // Register indices; the AHB byte address is four times the index
  localparam logic [3:0] IDX_OTG_CTRL = 4'h0;
  localparam logic [3:0] IDX_INT_EN_RISE = 4'h1;
  localparam logic [3:0] IDX_INT_EN_FALL = 4'h2;
  localparam logic [3:0] IDX_INT_STATUS = 4'h3;
  localparam logic [3:0] IDX_IO_PWR = 4'h4;
  localparam logic [3:0] IDX_EXT_IND = 4'h5;
  localparam logic [3:0] IDX_EVT_STATUS = 4'h6;
  localparam logic [3:0] IDX_EVT_MASK = 4'h7;
  localparam logic [3:0] IDX_LATENCY = 4'h8;
  localparam logic [3:0] IDX_LAST = 4'h8;

  // OTG control fields
  localparam int OTG_DISCHARGE_BIT = 3;
  localparam int OTG_CHARGE_BIT = 4;
  localparam int OTG_DRV_BIT = 5;
  localparam int OTG_DRV_EXT_BIT = 6;
  localparam logic [7:0] OTG_CTRL_RST = 8'h00;

  // Interrupt enable and status fields
  localparam int INT_VBUS_BIT = 1;
  localparam int INT_SESS_BIT = 2;
  localparam logic [7:0] INT_EN_RST = 8'h1F;

  // IO and power management fields
  localparam int IOP_UART_MODE_BIT = 0;
  localparam int IOP_UART_LVL_LSB = 1;
  localparam int IOP_DP_PU_BIT = 3;
  localparam int IOP_DM_PU_BIT = 4;
  localparam logic [7:0] IO_PWR_RST = 8'h00;
  localparam logic [1:0] REG_LEVEL_NORMAL = 2'h0;

  // External indicator control fields
  localparam int EXT_USE_BIT = 0;
  localparam int EXT_PASS_BIT = 1;
  localparam int EXT_COMP_BIT = 2;
  localparam logic [7:0] EXT_IND_RST = 8'h00;

  // Event bits
  localparam int EVT_VBUS_CHG = 0;
  localparam int EVT_TX_START = 1;
  localparam int EVT_UART_ENTER = 2;
  localparam int EVT_LINK_WRITE = 3;
  localparam logic [7:0] EVT_RST = 8'h00;

  // Receive end latency in high-speed clocks
  localparam logic [7:0] RX_END_LATENCY = 8'h2B;
  localparam logic [7:0] RX_END_LATENCY_MAX = 8'h3F;

  // ULPI command codes in bits 7:6
  localparam logic [1:0] CMD_TRANSMIT = 2'h1;
  localparam logic [1:0] CMD_REG_WRITE = 2'h2;
  localparam logic [1:0] CMD_REG_READ = 2'h3;

  typedef struct packed {
    logic en;
    logic [3:0] idx;
    logic [7:0] data;
  } ovc_reg_wr_s;

  typedef enum logic [3:0] {
    ULPI_IDLE,
    ULPI_WDATA,
    ULPI_WSTOP,
    ULPI_TX,
    ULPI_RTURN,
    ULPI_RDATA,
    ULPI_XTURN,
    ULPI_XCMD,
    ULPI_BACK
  } ovc_ulpi_state_e;

endpackage

//--- rtl/ovc_sync2.sv
`timescale 1ns/10ps
module ovc_sync2
  import ovc_pkg::*;
#(
  parameter int WIDTH = 4
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Asynchronous levels in, synchronised levels out
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1;

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      stage1 <= '0;
      syncOut <= '0;
    end
    else
    begin
      stage1 <= asyncIn;
      syncOut <= stage1;
    end
  end

endmodule

//--- rtl/ovc_vbus_select.sv
`timescale 1ns/10ps
module ovc_vbus_select
  import ovc_pkg::*;
(
  // Configuration
  input wire logic [7:0] intEnRise,
  input wire logic [7:0] intEnFall,
  input wire logic [7:0] extInd,
  // Synchronised comparator
  input wire logic vbusSync,
  // Results
  output logic cmpEnable,
  output logic statusVbus,
  output logic rxVbus
);

  logic useExt;
  logic passThru;
  logic complement;

  assign useExt = extInd[EXT_USE_BIT];
  assign passThru = extInd[EXT_PASS_BIT];
  assign complement = extInd[EXT_COMP_BIT];
  // Comparator off only when both edge enables are clear
  assign cmpEnable = intEnRise[INT_VBUS_BIT] | intEnFall[INT_VBUS_BIT];
  assign statusVbus = cmpEnable & vbusSync;

  always_comb
  begin
    if (!useExt)
      rxVbus = statusVbus;
    else if (passThru)
      rxVbus = !complement;
    else
      rxVbus = complement ? 1'b0 : statusVbus;
  end

endmodule

//--- rtl/ovc_vbus_ctrl.sv
// Operation
// - Clearing the VBUS-valid bit in both interrupt enable registers disables the comparator and status bit 1 reads 0.
// - After reset the RXCMD VBUS-valid value comes from the internal comparator.
// - With the external indicator on, pass-through without complement gives 1, complement gives 0 and neither gives the comparator.
// - The discharge resistor is connected exactly while OTG control bit 3 is set.
// - The charge pull-up is connected exactly while OTG control bit 4 is set.
// - The supply enable output is the OR of the two drive bits.
// - The supply enable output is active high.
// - Entering UART mode switches the regulator output to the UART level field.
// - In UART mode the line state is not shown on data bits 1 and 0.
// - The charger pull-ups are off while the active-low reset pin is low and follow their enables otherwise.
// - The receive end latency is 43 clocks, below the maximum of 63.
// - One protocol unit decodes link commands and routes them to the transmitter or the registers.
// - DIR is high while the device owns the bus and low while it watches for link commands.
`timescale 1ns/10ps
module ovc_vbus_ctrl
  import ovc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic irq,
  // ULPI
  input wire logic [7:0] ulpiDataIn,
  output logic [7:0] ulpiDataOut,
  output logic ulpiDataOe,
  output logic ulpiDir,
  output logic ulpiNxt,
  input wire logic ulpiStp,
  // Transmitter
  output logic [7:0] txData,
  output logic txValid,
  input wire logic txReady,
  // Analog side
  input wire logic vbusValidCmp,
  input wire logic sessionValidCmp,
  input wire logic [1:0] lineState,
  input wire logic activeLowReset,
  output logic vbusDischarge,
  output logic vbusCharge,
  output logic vbusSupplyEnableOut,
  output logic dpChargerPullup,
  output logic dmChargerPullup,
  output logic [1:0] regulatorLevel,
  output logic [7:0] rxEndLatency
);

  logic [7:0] otgCtrl;
  logic [7:0] intEnRise;
  logic [7:0] intEnFall;
  logic [7:0] ioPwr;
  logic [7:0] extInd;
  logic [7:0] evtStatus;
  logic [7:0] evtMask;
  logic [3:0] analogSync;
  logic vbusSync;
  logic sessSync;
  logic [1:0] lineSync;
  logic cmpEnable;
  logic statusVbus;
  logic rxVbus;
  logic dpValid;
  logic dpWrite;
  logic dpMapped;
  logic [3:0] dpIdx;
  logic addrPhase;
  logic addrMapped;
  ovc_reg_wr_s busWr;
  ovc_reg_wr_s linkWr;
  ovc_reg_wr_s regWr;
  ovc_ulpi_state_e state;
  ovc_ulpi_state_e next_state;
  logic [5:0] linkAddr;
  logic [7:0] rxcmdByte;
  logic [7:0] lastRxcmd;
  logic lastRxVbus;
  logic uartPrev;
  logic linkCmd;
  logic [1:0] cmdCode;
  logic txAccept;
  logic [7:0] evtSet;

  function automatic logic idxOk(input logic [5:0] a);
    idxOk = (a[5:4] == 2'h0) && (a[3:0] <= IDX_LAST);
  endfunction

  function automatic logic [7:0] regRead(input logic [3:0] idx);
    case (idx)
      IDX_OTG_CTRL: regRead = otgCtrl;
      IDX_INT_EN_RISE: regRead = intEnRise;
      IDX_INT_EN_FALL: regRead = intEnFall;
      IDX_INT_STATUS: regRead = {5'h00, sessSync, statusVbus, 1'b0};
      IDX_IO_PWR: regRead = ioPwr;
      IDX_EXT_IND: regRead = extInd;
      IDX_EVT_STATUS: regRead = evtStatus;
      IDX_EVT_MASK: regRead = evtMask;
      IDX_LATENCY: regRead = rxEndLatency;
      default: regRead = 8'h00;
    endcase
  endfunction

  ovc_sync2 #(.WIDTH(4)) uSync (
    .ref_clk(ref_clk),
    .reset(reset),
    .asyncIn({lineState, sessionValidCmp, vbusValidCmp}),
    .syncOut(analogSync)
  );
  assign vbusSync = analogSync[0];
  assign sessSync = analogSync[1];
  assign lineSync = analogSync[3:2];

  ovc_vbus_select uSelect (
    .intEnRise(intEnRise),
    .intEnFall(intEnFall),
    .extInd(extInd),
    .vbusSync(vbusSync),
    .cmpEnable(cmpEnable),
    .statusVbus(statusVbus),
    .rxVbus(rxVbus)
  );

  // AHB-Lite slave: zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign addrPhase = hsel && hready && htrans[1];
  assign addrMapped = (haddr[31:6] == 26'h0) && (haddr[1:0] == 2'h0) && idxOk({2'h0, haddr[5:2]});

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      dpValid <= 1'b0;
      dpWrite <= 1'b0;
      dpMapped <= 1'b0;
      dpIdx <= 4'h0;
      hrdata <= 32'h0000_0000;
    end
    else if (hready)
    begin
      dpValid <= addrPhase;
      dpWrite <= hwrite;
      dpMapped <= addrMapped;
      dpIdx <= haddr[5:2];
      hrdata <= (addrPhase && !hwrite && addrMapped) ? {24'h00_0000, regRead(haddr[5:2])} : 32'h0000_0000;
    end
  end

  // Register writes: bus has priority over the link
  assign busWr = '{en: dpValid && dpWrite && dpMapped, idx: dpIdx, data: hwdata[7:0]};
  assign regWr = busWr.en ? busWr : linkWr;

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      otgCtrl <= OTG_CTRL_RST;
      intEnRise <= INT_EN_RST;
      intEnFall <= INT_EN_RST;
      ioPwr <= IO_PWR_RST;
      extInd <= EXT_IND_RST;
      evtMask <= EVT_RST;
    end
    else if (regWr.en)
    begin
      case (regWr.idx)
        IDX_OTG_CTRL: otgCtrl <= regWr.data;
        IDX_INT_EN_RISE: intEnRise <= regWr.data;
        IDX_INT_EN_FALL: intEnFall <= regWr.data;
        IDX_IO_PWR: ioPwr <= regWr.data;
        IDX_EXT_IND: extInd <= regWr.data;
        IDX_EVT_MASK: evtMask <= regWr.data;
        default: ;
      endcase
    end
  end

  // Events; a new event wins over a write-one clear
  assign evtSet[EVT_VBUS_CHG] = rxVbus != lastRxVbus;
  assign evtSet[EVT_TX_START] = state == ULPI_IDLE && linkCmd && cmdCode == CMD_TRANSMIT && txReady;
  assign evtSet[EVT_UART_ENTER] = ioPwr[IOP_UART_MODE_BIT] && !uartPrev;
  assign evtSet[EVT_LINK_WRITE] = linkWr.en;
  assign evtSet[7:4] = 4'h0;

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      evtStatus <= EVT_RST;
      lastRxVbus <= 1'b0;
      uartPrev <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      if (regWr.en && regWr.idx == IDX_EVT_STATUS)
        evtStatus <= (evtStatus & ~regWr.data) | evtSet;
      else
        evtStatus <= evtStatus | evtSet;
      lastRxVbus <= rxVbus;
      uartPrev <= ioPwr[IOP_UART_MODE_BIT];
      irq <= |(evtStatus & evtMask);
    end
  end

  // Analog controls
  assign vbusDischarge = otgCtrl[OTG_DISCHARGE_BIT];
  assign vbusCharge = otgCtrl[OTG_CHARGE_BIT];
  assign vbusSupplyEnableOut = otgCtrl[OTG_DRV_BIT] | otgCtrl[OTG_DRV_EXT_BIT];
  assign dpChargerPullup = activeLowReset & ioPwr[IOP_DP_PU_BIT];
  assign dmChargerPullup = activeLowReset & ioPwr[IOP_DM_PU_BIT];
  assign regulatorLevel = ioPwr[IOP_UART_MODE_BIT] ? ioPwr[IOP_UART_LVL_LSB +: 2] : REG_LEVEL_NORMAL;
  assign rxEndLatency = RX_END_LATENCY;

  // ULPI protocol unit
  assign rxcmdByte = {4'h0, rxVbus ? 2'h3 : (sessSync ? 2'h2 : 2'h0),
    ioPwr[IOP_UART_MODE_BIT] ? 2'h0 : lineSync};
  assign linkCmd = ulpiDataIn != 8'h00;
  assign cmdCode = ulpiDataIn[7:6];
  assign ulpiDir = !(state == ULPI_IDLE || state == ULPI_WDATA || state == ULPI_WSTOP
    || state == ULPI_TX || state == ULPI_BACK);
  assign txAccept = txReady && ((state == ULPI_IDLE && linkCmd && cmdCode == CMD_TRANSMIT)
    || (state == ULPI_TX && !ulpiStp));
  assign ulpiNxt = txAccept || state == ULPI_WDATA
    || (state == ULPI_IDLE && linkCmd && cmdCode[1]);
  assign linkWr = '{en: state == ULPI_WDATA && idxOk(linkAddr), idx: linkAddr[3:0], data: ulpiDataIn};

  always_comb
  begin
    next_state = state;
    unique case (state)
      ULPI_IDLE:
        if (linkCmd)
        begin
          if (cmdCode == CMD_REG_WRITE)
            next_state = ULPI_WDATA;
          else if (cmdCode == CMD_REG_READ)
            next_state = ULPI_RTURN;
          else if (cmdCode == CMD_TRANSMIT && txReady)
            next_state = ULPI_TX;
        end
        else if (rxcmdByte != lastRxcmd)
          next_state = ULPI_XTURN;
      ULPI_WDATA: next_state = ULPI_WSTOP;
      ULPI_WSTOP: next_state = ULPI_IDLE;
      ULPI_TX: next_state = ulpiStp ? ULPI_IDLE : ULPI_TX;
      ULPI_RTURN: next_state = ULPI_RDATA;
      ULPI_RDATA: next_state = ULPI_BACK;
      ULPI_XTURN: next_state = ULPI_XCMD;
      ULPI_XCMD: next_state = ULPI_BACK;
      ULPI_BACK: next_state = ULPI_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      state <= ULPI_IDLE;
      linkAddr <= 6'h00;
      lastRxcmd <= 8'h00;
      ulpiDataOut <= 8'h00;
      ulpiDataOe <= 1'b0;
    end
    else
    begin
      state <= next_state;
      if (state == ULPI_IDLE && linkCmd)
        linkAddr <= ulpiDataIn[5:0];
      ulpiDataOe <= next_state == ULPI_RDATA || next_state == ULPI_XCMD;
      if (next_state == ULPI_RDATA)
        ulpiDataOut <= idxOk(linkAddr) ? regRead(linkAddr[3:0]) : 8'h00;
      else if (next_state == ULPI_XCMD)
      begin
        ulpiDataOut <= rxcmdByte;
        lastRxcmd <= rxcmdByte;
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      txData <= 8'h00;
      txValid <= 1'b0;
    end
    else
    begin
      txValid <= txAccept;
      if (txAccept)
        txData <= ulpiDataIn;
    end
  end

  // Checks
  sequence s_otg_write(int b);
    dpValid && dpWrite && dpMapped && dpIdx == IDX_OTG_CTRL && hwdata[b];
  endsequence

  sequence s_read_turn;
    ulpiDir ##1 ulpiDir && ulpiDataOe ##1 !ulpiDir && !ulpiDataOe;
  endsequence

  a_vbus_gate_off: assert property (@(posedge ref_clk) disable iff (reset)
    dpValid && !dpWrite && dpIdx == IDX_INT_STATUS && $past(!cmpEnable) |-> !hrdata[INT_VBUS_BIT])
    else $error("vbus status reads set while comparator disabled");
  a_default_source: assert property (@(posedge ref_clk) disable iff (reset)
    !extInd[EXT_USE_BIT] |-> rxVbus == (vbusSync && cmpEnable))
    else $error("rxcmd vbus source not internal comparator");
  a_fixed_zero: assert property (@(posedge ref_clk) disable iff (reset)
    extInd[EXT_USE_BIT] && extInd[EXT_COMP_BIT] |-> !rxVbus)
    else $error("complemented external indicator not zero");
  a_discharge_follow: assert property (@(posedge ref_clk) disable iff (reset)
    s_otg_write(OTG_DISCHARGE_BIT) |=> vbusDischarge)
    else $error("discharge did not follow control bit");
  a_charge_follow: assert property (@(posedge ref_clk) disable iff (reset)
    s_otg_write(OTG_CHARGE_BIT) |=> vbusCharge)
    else $error("charge did not follow control bit");
  a_supply_either: assert property (@(posedge ref_clk) disable iff (reset)
    s_otg_write(OTG_DRV_EXT_BIT) |=> vbusSupplyEnableOut)
    else $error("supply enable not set by external drive bit");
  a_supply_reset: assert property (@(posedge ref_clk)
    reset ##1 !reset |-> !vbusSupplyEnableOut && !otgCtrl[OTG_DRV_BIT] && !otgCtrl[OTG_DRV_EXT_BIT])
    else $error("supply enable high after reset");
  a_uart_level: assert property (@(posedge ref_clk) disable iff (reset)
    $rose(ioPwr[IOP_UART_MODE_BIT]) |-> regulatorLevel == ioPwr[IOP_UART_LVL_LSB +: 2])
    else $error("regulator level not switched in uart mode");
  a_uart_linestate: assert property (@(posedge ref_clk) disable iff (reset)
    state == ULPI_XCMD && $past(ioPwr[IOP_UART_MODE_BIT]) |-> ulpiDataOut[1:0] == 2'h0)
    else $error("line state shown in uart mode");
  a_pullup_gate: assert property (@(posedge ref_clk) disable iff (reset)
    !activeLowReset |-> !dpChargerPullup && !dmChargerPullup)
    else $error("charger pull-up on during pin reset");
  a_latency_limit: assert property (@(posedge ref_clk) disable iff (reset)
    rxEndLatency == RX_END_LATENCY && rxEndLatency < RX_END_LATENCY_MAX)
    else $error("receive end latency out of range");
  a_read_turn: assert property (@(posedge ref_clk) disable iff (reset)
    state == ULPI_IDLE && linkCmd && cmdCode == CMD_REG_READ |=> s_read_turn)
    else $error("register read turnaround wrong");

endmodule

//--- verif/ovc_link_model.sv
`timescale 1ns/10ps
module ovc_link_model
  import ovc_pkg::*;
(
  // Clock
  input wire logic ref_clk,
  // ULPI from the device
  input wire logic [7:0] ulpiDataOut,
  input wire logic ulpiDataOe,
  input wire logic ulpiDir,
  input wire logic ulpiNxt,
  // ULPI to the device
  output logic [7:0] ulpiDataIn,
  output logic ulpiStp,
  // Last receive command byte
  output logic [7:0] lastRxcmd
);
  logic [7:0] linkData;
  logic linkOe;
  logic reading;
  logic [7:0] lastBus;

  // Nobody drives in turn-around: show a pattern that changes every cycle
  assign ulpiDataIn = ulpiDataOe ? ulpiDataOut : ((linkOe && !ulpiDir) ? linkData : ~lastBus);

  initial
  begin
    linkData = 8'h00;
    linkOe = 1'b1;
    ulpiStp = 1'b0;
    reading = 1'b0;
    lastRxcmd = 8'h00;
    lastBus = 8'h00;
  end

  always @(posedge ref_clk)
  begin
    lastBus <= ulpiDataIn;
    if (ulpiDataOe && !reading)
      lastRxcmd <= ulpiDataOut;
  end

  // Start only once the device has released the bus
  task automatic waitBusFree;
    logic d;
    do
    begin
      @(negedge ref_clk);
      d = ulpiDir;
      @(posedge ref_clk);
    end
    while (d !== 1'b0);
  endtask

  // Hold a byte until the device accepts it
  task automatic sendByte(input logic [7:0] b);
    logic seen;
    linkData <= b;
    do
    begin
      @(negedge ref_clk);
      seen = ulpiNxt;
      @(posedge ref_clk);
    end
    while (seen !== 1'b1);
  endtask

  task automatic sendFrame(input logic [7:0] c, input logic [7:0] d);
    waitBusFree();
    sendByte(c);
    sendByte(d);
    linkData <= 8'h00;
    ulpiStp <= 1'b1;
    @(posedge ref_clk);
    ulpiStp <= 1'b0;
  endtask

  task automatic regWrite(input logic [3:0] idx, input logic [7:0] d);
    sendFrame({CMD_REG_WRITE, 2'b00, idx}, d);
  endtask

  task automatic regRead(input logic [3:0] idx, output logic [7:0] d);
    logic oe;
    waitBusFree();
    reading <= 1'b1;
    sendByte({CMD_REG_READ, 2'b00, idx});
    linkOe <= 1'b0;
    do
    begin
      @(negedge ref_clk);
      oe = ulpiDataOe;
      d = ulpiDataOut;
      @(posedge ref_clk);
    end
    while (oe !== 1'b1);
    waitBusFree();
    linkData <= 8'h00;
    linkOe <= 1'b1;
    reading <= 1'b0;
  endtask
endmodule

//--- verif/otg_vbus_control_logic_tb.sv
`timescale 1ns/10ps
module otg_vbus_control_logic_tb
  import ovc_pkg::*;
;
  logic ref_clk, reset, hsel, hwrite, hready, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, lineState, regulatorLevel;
  logic [2:0] hsize;
  logic [7:0] ulpiDataIn, ulpiDataOut, txData, rxEndLatency, lastRxcmd, ud;
  logic ulpiDataOe, ulpiDir, ulpiNxt, ulpiStp, txValid, txReady;
  logic vbusValidCmp, sessionValidCmp, activeLowReset;
  logic vbusDischarge, vbusCharge, vbusSupplyEnableOut, dpChargerPullup, dmChargerPullup;
  logic [7:0] extTab [5] = '{8'h00, 8'h03, 8'h07, 8'h01, 8'h05};
  logic [7:0] txSeen [$];
  int fail_count, checks_done;

  assign hready = hreadyout;
  always #25 ref_clk = ~ref_clk;

  ovc_vbus_ctrl DUT (.ref_clk(ref_clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .ulpiDataIn(ulpiDataIn), .ulpiDataOut(ulpiDataOut),
    .ulpiDataOe(ulpiDataOe), .ulpiDir(ulpiDir), .ulpiNxt(ulpiNxt), .ulpiStp(ulpiStp), .txData(txData),
    .txValid(txValid), .txReady(txReady), .vbusValidCmp(vbusValidCmp), .sessionValidCmp(sessionValidCmp),
    .lineState(lineState), .activeLowReset(activeLowReset), .vbusDischarge(vbusDischarge),
    .vbusCharge(vbusCharge), .vbusSupplyEnableOut(vbusSupplyEnableOut), .dpChargerPullup(dpChargerPullup),
    .dmChargerPullup(dmChargerPullup), .regulatorLevel(regulatorLevel), .rxEndLatency(rxEndLatency));

  ovc_link_model link (.ref_clk(ref_clk), .ulpiDataOut(ulpiDataOut), .ulpiDataOe(ulpiDataOe),
    .ulpiDir(ulpiDir), .ulpiNxt(ulpiNxt), .ulpiDataIn(ulpiDataIn), .ulpiStp(ulpiStp), .lastRxcmd(lastRxcmd));

  always @(negedge ref_clk)
    if (txValid === 1'b1)
      txSeen.push_back(txData);

  task automatic complete_run;
    $display("checks %0d errors %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Wait for the edge at which hready is high; read data is the value standing then
  task automatic waitReady;
    logic rdy;
    do
    begin
      @(negedge ref_clk);
      rdy = hready;
      rd = hrdata;
      @(posedge ref_clk);
    end
    while (rdy !== 1'b1);
  endtask

  task automatic acc(input logic wr, input logic [3:0] idx, input logic [31:0] wd);
    @(posedge ref_clk);
    haddr <= {26'h0, idx, 2'b00};
    htrans <= 2'h2;
    hwrite <= wr;
    waitReady();
    htrans <= 2'h0;
    hwdata <= wd;
    waitReady();
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  initial
  begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    complete_run();
  end

  initial
  begin
    ref_clk = 0; reset = 1; hsel = 1; hwrite = 0; htrans = 0; hsize = 3'h2; haddr = 0; hwdata = 0;
    txReady = 1; vbusValidCmp = 0; sessionValidCmp = 0; lineState = 0; activeLowReset = 1;
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    acc(0, IDX_OTG_CTRL, 0);
    check("otg ctrl", 32'h0, rd);
    check("supply enable", 0, vbusSupplyEnableOut);
    check("hresp okay", 0, hresp);
    acc(0, IDX_EXT_IND, 0);
    check("ext ind", 32'h0, rd);
    acc(0, IDX_LATENCY, 0);
    check("latency reg", 32'h2B, rd);
    check("latency pin", 32'h2B, rxEndLatency);
    acc(0, 4'hF, 0);
    check("unmapped", 32'h0, rd);
    for (int i = 0; i < 16; i++)
    begin
      acc(1, IDX_OTG_CTRL, i << 3);
      @(negedge ref_clk);
      check("discharge", i[0], vbusDischarge);
      check("charge", i[1], vbusCharge);
      check("supply", i[2] | i[3], vbusSupplyEnableOut);
    end
    @(posedge ref_clk);
    vbusValidCmp <= 1'b1;
    // Two synchroniser stages before the status register sees it
    cyc(2);
    acc(0, IDX_INT_STATUS, 0);
    check("status vbus", 1, rd[1]);
    acc(1, IDX_INT_EN_RISE, 32'h1D);
    acc(0, IDX_INT_STATUS, 0);
    check("status one enable", 1, rd[1]);
    acc(1, IDX_INT_EN_FALL, 32'h1D);
    acc(0, IDX_INT_STATUS, 0);
    check("status disabled", 0, rd[1]);
    acc(1, IDX_INT_EN_RISE, 32'h1F);
    acc(1, IDX_INT_EN_FALL, 32'h1F);
    for (int c = 0; c < 2; c++)
    begin
      @(posedge ref_clk);
      vbusValidCmp <= c[0];
      for (int k = 0; k < 5; k++)
      begin
        acc(1, IDX_EXT_IND, {24'h0, extTab[k]});
        cyc(12);
        @(negedge ref_clk);
        check("rxcmd vbus", (k == 1 || ((k == 0 || k == 3) && c == 1)) ? 2'b11 : 2'b00, lastRxcmd[3:2]);
      end
    end
    @(posedge ref_clk);
    sessionValidCmp <= 1'b1;
    cyc(12);
    @(negedge ref_clk);
    check("rxcmd session", 2'b10, lastRxcmd[3:2]);
    @(posedge ref_clk);
    lineState <= 2'b11;
    acc(1, IDX_EVT_MASK, 32'h04);
    acc(1, IDX_IO_PWR, 32'h05);
    cyc(12);
    @(negedge ref_clk);
    check("regulator", 2'b10, regulatorLevel);
    check("uart linestate", 2'b00, lastRxcmd[1:0]);
    check("irq raised", 1, irq);
    acc(1, IDX_EVT_MASK, 0);
    cyc(2);
    @(negedge ref_clk);
    check("irq masked", 0, irq);
    acc(1, IDX_EVT_MASK, 32'h04);
    cyc(2);
    @(negedge ref_clk);
    check("irq unmasked", 1, irq);
    acc(1, IDX_EVT_STATUS, 32'h04);
    cyc(2);
    @(negedge ref_clk);
    check("irq cleared", 0, irq);
    acc(0, IDX_EVT_STATUS, 0);
    check("event cleared", 0, rd[2]);
    acc(1, IDX_IO_PWR, 0);
    cyc(12);
    @(negedge ref_clk);
    check("regulator normal", REG_LEVEL_NORMAL, regulatorLevel);
    check("linestate", 2'b11, lastRxcmd[1:0]);
    for (int j = 0; j < 2; j++)
    begin
      acc(1, IDX_IO_PWR, 32'h08 << j);
      @(negedge ref_clk);
      check("dp pullup", j == 0, dpChargerPullup);
      check("dm pullup", j == 1, dmChargerPullup);
    end
    @(posedge ref_clk);
    activeLowReset <= 1'b0;
    @(negedge ref_clk);
    check("dm pullup held off", 0, dmChargerPullup);
    link.regWrite(IDX_OTG_CTRL, 8'h40);
    @(negedge ref_clk);
    check("link write supply", 1, vbusSupplyEnableOut);
    acc(0, IDX_OTG_CTRL, 0);
    check("link write reg", 32'h40, rd);
    link.regRead(IDX_LATENCY, ud);
    check("link read latency", 8'h2B, ud);
    txSeen.delete();
    txReady <= 1'b0;
    fork
      link.sendFrame({CMD_TRANSMIT, 6'h03}, 8'hA5);
      begin
        cyc(4);
        txReady <= 1'b1;
      end
    join
    cyc(3);
    check("tx count", 2, txSeen.size());
    check("tx cmd", {CMD_TRANSMIT, 6'h03}, txSeen[0]);
    check("tx byte", 8'hA5, txSeen[1]);
    // Vbus change, transmit start and link write are pending; uart entry was cleared
    acc(0, IDX_EVT_STATUS, 0);
    check("event flags", 32'h0B, rd);
    complete_run();
  end
endmodule
